//--- src/vcc_pkg.sv
// constants, offsets and reset values of the capture configuration bank
package vcc_pkg;
    localparam logic [7:0] VCC_SILICON_REV = 8'h01; // value arbitrary
    localparam logic [6:0] VCC_DEV_ADDR = 7'h4C; // value arbitrary
    // ------------------------------------------
    // register offsets
    // ------------------------------------------
    localparam logic [7:0] ADR_SILICON_REVISION = 8'h00;
    localparam logic [7:0] ADR_DIVIDE_HIGH_BYTE = 8'h01;
    localparam logic [7:0] ADR_DIVIDE_LOW_NIBBLE = 8'h02;
    localparam logic [7:0] ADR_CLOCK_GEN_CONTROL = 8'h03;
    localparam logic [7:0] ADR_SAMPLING_PHASE = 8'h04;
    localparam logic [7:0] ADR_CLAMP_START = 8'h05;
    localparam logic [7:0] ADR_CLAMP_LENGTH = 8'h06;
    localparam logic [7:0] ADR_SYNC_OUT_WIDTH = 8'h07;
    localparam logic [7:0] ADR_RED_GAIN = 8'h08;
    localparam logic [7:0] ADR_GREEN_GAIN = 8'h09;
    localparam logic [7:0] ADR_BLUE_GAIN = 8'h0A;
    localparam logic [7:0] ADR_RED_OFFSET = 8'h0B;
    localparam logic [7:0] ADR_GREEN_OFFSET = 8'h0C;
    localparam logic [7:0] ADR_INPUT_CONTROL = 8'h0F;
    // ------------------------------------------
    // field positions and masks
    // ------------------------------------------
    localparam int VCO_MSB = 7;
    localparam int VCO_LSB = 6;
    localparam int PUMP_MSB = 5;
    localparam int PUMP_LSB = 3;
    localparam int PHASE_MSB = 7;
    localparam int PHASE_LSB = 3;
    localparam int CLAMP_SRC_BIT = 7;
    localparam logic [7:0] OFFSET_MASK = 8'hFE;
    localparam logic [7:0] INPUT_CTRL_MASK = 8'h80;
    // ------------------------------------------
    // reset values
    // ------------------------------------------
    localparam logic [11:0] DIVIDE_RESET = 12'h69D;
    localparam logic [7:0] RST_DIVIDE_HIGH = 8'h69;
    localparam logic [7:0] RST_DIVIDE_LOW = 8'hD0;
    localparam logic [7:0] RST_CLOCK_GEN = 8'h48;
    localparam logic [7:0] RST_PHASE = 8'h80;
    localparam logic [7:0] RST_CLAMP_START = 8'h08;
    localparam logic [7:0] RST_CLAMP_LENGTH = 8'h14;
    localparam logic [7:0] RST_SYNC_WIDTH = 8'h20;
    localparam logic [7:0] RST_GAIN = 8'h80;
    localparam logic [7:0] RST_OFFSET = 8'h7E;
    localparam logic [7:0] RST_INPUT_CTRL = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        VCC_IDLE = 4'h0,
        VCC_ADDR = 4'h1,
        VCC_ADDR_ACK = 4'h3,
        VCC_SUB = 4'h2,
        VCC_SUB_ACK = 4'h6,
        VCC_WDAT = 4'h7,
        VCC_WDAT_ACK = 4'h5,
        VCC_RDAT = 4'hC,
        VCC_RACK = 4'hD
    } vcc_state_t;

    // writable register map
    function automatic logic vcc_is_rw(input logic [7:0] a);
        if (a >= ADR_DIVIDE_HIGH_BYTE && a <= ADR_GREEN_OFFSET) begin
            vcc_is_rw = 1'b1;
        end else if (a == ADR_INPUT_CONTROL) begin
            vcc_is_rw = 1'b1;
        end else begin
            vcc_is_rw = 1'b0;
        end
    endfunction

    // value of each storage slot after reset
    function automatic logic [7:0] vcc_reset_value(input logic [3:0] i);
        case (i)
            4'h1: vcc_reset_value = RST_DIVIDE_HIGH;
            4'h2: vcc_reset_value = RST_DIVIDE_LOW;
            4'h3: vcc_reset_value = RST_CLOCK_GEN;
            4'h4: vcc_reset_value = RST_PHASE;
            4'h5: vcc_reset_value = RST_CLAMP_START;
            4'h6: vcc_reset_value = RST_CLAMP_LENGTH;
            4'h7: vcc_reset_value = RST_SYNC_WIDTH;
            4'h8, 4'h9, 4'hA: vcc_reset_value = RST_GAIN;
            4'hB, 4'hC: vcc_reset_value = RST_OFFSET;
            default: vcc_reset_value = 8'h00;
        endcase
    endfunction
endpackage

//--- src/vcc_config_timing.sv
// configuration bank, serial slave and pixel timing of the capture front end
`timescale 1ns/1ps
module vcc_config_timing (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic hsync_in,
    input wire logic clamp_pin_in,
    output logic [11:0] line_divide_value,
    output logic feedback_pulse,
    output logic [1:0] vco_range,
    output logic [2:0] pump_current,
    output logic [4:0] sample_phase,
    output logic [7:0] red_gain,
    output logic [7:0] green_gain,
    output logic [7:0] blue_gain,
    output logic [6:0] red_offset,
    output logic [6:0] green_offset,
    output logic sync_out,
    output logic clamp_out
);
    // ------------------------------------------
    // serial port
    // ------------------------------------------
    vcc_pkg::vcc_state_t state_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic nack_reg;
    logic wr_stb_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] cfg_reg [0:15];
    logic [7:0] act_reg [0:15];
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] ptr_inc;

    assign scl_rise = scl_in & ~scl_q_reg;
    assign scl_fall = ~scl_in & scl_q_reg;
    assign bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign bus_stop = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    assign ptr_inc = ptr_reg + 8'h01;

    function automatic logic [7:0] rd_value(input logic [7:0] a);
        if (a == vcc_pkg::ADR_SILICON_REVISION) begin
            rd_value = vcc_pkg::VCC_SILICON_REV;
        end else if (vcc_pkg::vcc_is_rw(a)) begin
            rd_value = cfg_reg[a[3:0]];
        end else begin
            rd_value = 8'h00;
        end
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= vcc_pkg::VCC_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'hFF;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_stb_reg <= 1'b0;
            if (bus_start) begin
                state_reg <= vcc_pkg::VCC_ADDR;
                bit_cnt_reg <= 4'h0;
                tx_reg <= 8'hFF;
            end else if (bus_stop) begin
                state_reg <= vcc_pkg::VCC_IDLE;
                tx_reg <= 8'hFF;
            end else if (scl_rise) begin
                if (state_reg == vcc_pkg::VCC_RACK) begin
                    nack_reg <= sda_in;
                end else if (state_reg == vcc_pkg::VCC_ADDR || state_reg == vcc_pkg::VCC_SUB ||
                             state_reg == vcc_pkg::VCC_WDAT) begin
                    rx_reg <= {rx_reg[6:0], sda_in};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
            end else if (scl_fall) begin
                case (state_reg)
                    vcc_pkg::VCC_ADDR: begin
                        if (bit_cnt_reg == vcc_pkg::BITS_PER_BYTE) begin
                            if (rx_reg[7:1] == vcc_pkg::VCC_DEV_ADDR) begin
                                state_reg <= vcc_pkg::VCC_ADDR_ACK;
                                rw_reg <= rx_reg[0];
                            end else begin
                                state_reg <= vcc_pkg::VCC_IDLE;
                            end
                        end
                    end
                    vcc_pkg::VCC_ADDR_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            state_reg <= vcc_pkg::VCC_RDAT;
                            tx_reg <= rd_value(ptr_reg);
                        end else begin
                            state_reg <= vcc_pkg::VCC_SUB;
                        end
                    end
                    vcc_pkg::VCC_SUB: begin
                        if (bit_cnt_reg == vcc_pkg::BITS_PER_BYTE) begin
                            state_reg <= vcc_pkg::VCC_SUB_ACK;
                            ptr_reg <= rx_reg;
                        end
                    end
                    vcc_pkg::VCC_SUB_ACK: begin
                        state_reg <= vcc_pkg::VCC_WDAT;
                        bit_cnt_reg <= 4'h0;
                    end
                    vcc_pkg::VCC_WDAT: begin
                        if (bit_cnt_reg == vcc_pkg::BITS_PER_BYTE) begin
                            state_reg <= vcc_pkg::VCC_WDAT_ACK;
                            wr_stb_reg <= 1'b1;
                            wr_addr_reg <= ptr_reg;
                            wr_data_reg <= rx_reg;
                        end
                    end
                    vcc_pkg::VCC_WDAT_ACK: begin
                        state_reg <= vcc_pkg::VCC_WDAT;
                        bit_cnt_reg <= 4'h0;
                        ptr_reg <= ptr_inc;
                    end
                    vcc_pkg::VCC_RDAT: begin
                        if (bit_cnt_reg == 4'h7) begin
                            state_reg <= vcc_pkg::VCC_RACK;
                            tx_reg <= 8'hFF;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b1};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    vcc_pkg::VCC_RACK: begin
                        if (nack_reg) begin
                            state_reg <= vcc_pkg::VCC_IDLE;
                        end else begin
                            state_reg <= vcc_pkg::VCC_RDAT;
                            bit_cnt_reg <= 4'h0;
                            ptr_reg <= ptr_inc;
                            tx_reg <= rd_value(ptr_inc);
                        end
                    end
                    default: begin
                        state_reg <= vcc_pkg::VCC_IDLE;
                    end
                endcase
            end
        end
    end

    // open-drain data line, pulled low only
    assign sda_out = 1'b0;
    assign sda_oe = (state_reg == vcc_pkg::VCC_ADDR_ACK) | (state_reg == vcc_pkg::VCC_SUB_ACK) |
                    (state_reg == vcc_pkg::VCC_WDAT_ACK) | ((state_reg == vcc_pkg::VCC_RDAT) & ~tx_reg[7]);

    // ------------------------------------------
    // register store
    // ------------------------------------------
    logic wr_low_nibble;
    logic line_edge;
    logic divide_pend_reg;
    logic [11:0] divide_staged;
    logic [11:0] div_cnt_reg;

    assign wr_low_nibble = wr_stb_reg & (wr_addr_reg == vcc_pkg::ADR_DIVIDE_LOW_NIBBLE);
    assign divide_staged = {cfg_reg[1], cfg_reg[2][7:4]};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                cfg_reg[i] <= vcc_pkg::vcc_reset_value(4'(i));
            end
        end else if (wr_stb_reg && vcc_pkg::vcc_is_rw(wr_addr_reg)) begin
            if (wr_addr_reg == vcc_pkg::ADR_RED_OFFSET || wr_addr_reg == vcc_pkg::ADR_GREEN_OFFSET) begin
                cfg_reg[wr_addr_reg[3:0]] <= wr_data_reg & vcc_pkg::OFFSET_MASK;
            end else if (wr_addr_reg == vcc_pkg::ADR_INPUT_CONTROL) begin
                cfg_reg[wr_addr_reg[3:0]] <= wr_data_reg & vcc_pkg::INPUT_CTRL_MASK;
            end else begin
                cfg_reg[wr_addr_reg[3:0]] <= wr_data_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                act_reg[i] <= vcc_pkg::vcc_reset_value(4'(i));
            end
        end else if (line_edge) begin
            for (int i = 0; i < 16; i++) begin
                act_reg[i] <= cfg_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            divide_pend_reg <= 1'b0;
        end else if (wr_low_nibble) begin
            divide_pend_reg <= 1'b1;
        end else if (line_edge) begin
            divide_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_divide_value <= vcc_pkg::DIVIDE_RESET;
        end else if (line_edge && divide_pend_reg) begin
            line_divide_value <= divide_staged;
        end
    end

    // ------------------------------------------
    // line divider and sync output
    // ------------------------------------------
    logic [7:0] sync_cnt_reg;

    assign line_edge = (div_cnt_reg >= line_divide_value);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 12'h000;
            feedback_pulse <= 1'b0;
        end else begin
            div_cnt_reg <= line_edge ? 12'h000 : div_cnt_reg + 12'h001;
            feedback_pulse <= line_edge;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_cnt_reg <= 8'h00;
        end else if (feedback_pulse) begin
            sync_cnt_reg <= act_reg[7];
        end else if (sync_cnt_reg != 8'h00) begin
            sync_cnt_reg <= sync_cnt_reg - 8'h01;
        end
    end
    assign sync_out = (sync_cnt_reg != 8'h00);

    // ------------------------------------------
    // clamp timing
    // ------------------------------------------
    logic hs_q_reg;
    logic hs_fall;
    logic clamp_ext;
    logic [7:0] dly_cnt_reg;
    logic [7:0] len_cnt_reg;

    assign hs_fall = hs_q_reg & ~hsync_in;
    assign clamp_ext = act_reg[15][vcc_pkg::CLAMP_SRC_BIT];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_q_reg <= 1'b0;
            dly_cnt_reg <= 8'h00;
            len_cnt_reg <= 8'h00;
        end else begin
            hs_q_reg <= hsync_in;
            if (hs_fall) begin
                dly_cnt_reg <= act_reg[5];
            end else if (dly_cnt_reg != 8'h00) begin
                dly_cnt_reg <= dly_cnt_reg - 8'h01;
            end
            if (dly_cnt_reg == 8'h01 && !hs_fall) begin
                len_cnt_reg <= act_reg[6];
            end else if (len_cnt_reg != 8'h00) begin
                len_cnt_reg <= len_cnt_reg - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clamp_out <= 1'b0;
        end else begin
            clamp_out <= clamp_ext ? clamp_pin_in : (len_cnt_reg != 8'h00);
        end
    end

    assign vco_range = act_reg[3][vcc_pkg::VCO_MSB:vcc_pkg::VCO_LSB];
    assign pump_current = act_reg[3][vcc_pkg::PUMP_MSB:vcc_pkg::PUMP_LSB];
    assign sample_phase = act_reg[4][vcc_pkg::PHASE_MSB:vcc_pkg::PHASE_LSB];
    assign red_gain = act_reg[8];
    assign green_gain = act_reg[9];
    assign blue_gain = act_reg[10];
    assign red_offset = act_reg[11][7:1];
    assign green_offset = act_reg[12][7:1];

    // ------------------------------------------
    // assertions
    // ------------------------------------------
    property p_rev_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (scl_fall && !bus_start && !bus_stop && state_reg == vcc_pkg::VCC_ADDR_ACK && rw_reg &&
         ptr_reg == 8'h00) |=> (tx_reg == vcc_pkg::VCC_SILICON_REV);
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision byte not loaded");

    property p_div_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !divide_pend_reg && !wr_low_nibble |=> $stable(line_divide_value);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divide changed without low write");

    property p_div_load;
        @(posedge sys_clk) disable iff (!rst_n)
        divide_pend_reg && line_edge |=> (line_divide_value == $past(divide_staged));
    endproperty
    a_div_load: assert property (p_div_load) else $error("divide parts not loaded together");

    property p_div_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        line_edge |=> (div_cnt_reg == 12'h000) ##1 (div_cnt_reg == 12'h001 || feedback_pulse);
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("line divider wrap wrong");

    property p_sync_start;
        @(posedge sys_clk) disable iff (!rst_n)
        feedback_pulse && act_reg[7] != 8'h00 |=> sync_out;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync output not started");

    property p_sync_end;
        @(posedge sys_clk) disable iff (!rst_n)
        sync_cnt_reg == 8'h01 && !feedback_pulse |=> !sync_out;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("sync output width wrong");

    property p_clamp_int;
        @(posedge sys_clk) disable iff (!rst_n)
        !clamp_ext && dly_cnt_reg == 8'h01 && !hs_fall && act_reg[6] != 8'h00 |=> ##1 clamp_out;
    endproperty
    a_clamp_int: assert property (p_clamp_int) else $error("internal clamp not started");

    property p_clamp_ext;
        @(posedge sys_clk) disable iff (!rst_n)
        clamp_ext |=> (clamp_out == $past(clamp_pin_in));
    endproperty
    a_clamp_ext: assert property (p_clamp_ext) else $error("external clamp not followed");

    property p_apply;
        @(posedge sys_clk) disable iff (!rst_n)
        line_edge |=> (vco_range == $past(cfg_reg[3][7:6]));
    endproperty
    a_apply: assert property (p_apply) else $error("range not applied at line boundary");
endmodule

//--- sim/vcc_host_model.sv
// two-wire serial host model for the configuration port
`timescale 1ns/1ps
module vcc_host_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    int nacks = 0;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hp;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    task automatic xbit(input logic b, output logic r);
        sda = b;
        hp;
        scl = 1'b1;
        hp;
        r = sda_line;
        scl = 1'b0;
        hp;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic k, input logic c, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(k, a);
        if (c && a !== 1'b0) nacks++;
    endtask
    task automatic start;
        sda = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda = 1'b0;
        hp;
        scl = 1'b0;
        hp;
    endtask
    task automatic stop;
        sda = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda = 1'b1;
        hp;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        start;
        xbyte({vcc_pkg::VCC_DEV_ADDR, 1'b0}, 1'b1, 1'b1, q);
        xbyte(a, 1'b1, 1'b1, q);
        xbyte(d, 1'b1, 1'b1, q);
        stop;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        start;
        xbyte({vcc_pkg::VCC_DEV_ADDR, 1'b0}, 1'b1, 1'b1, q);
        xbyte(a, 1'b1, 1'b1, q);
        start;
        xbyte({vcc_pkg::VCC_DEV_ADDR, 1'b1}, 1'b1, 1'b1, q);
        xbyte(8'hFF, 1'b1, 1'b0, q);
        stop;
    endtask
endmodule

//--- sim/vcc_config_timing_tb_top.sv
// self-checking bench of the capture configuration bank
`timescale 1ns/1ps
module vcc_config_timing_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, hsync_in = 1'b0, clamp_pin_in = 1'b0;
    logic scl, host_sda, sda_line, sda_out, sda_oe, feedback_pulse, sync_out, clamp_out;
    logic [11:0] line_divide_value;
    logic [1:0] vco_range;
    logic [2:0] pump_current;
    logic [4:0] sample_phase;
    logic [7:0] red_gain, green_gain, blue_gain, q, hi, cg, ph, w, p, d;
    logic [7:0] g [3];
    logic [6:0] red_offset, green_offset;
    logic [3:0] lo;
    logic [11:0] cur;
    logic [31:0] v;
    int n_errors = 0, cmp_count = 0, cyc = 0, k, c;
    integer seed = 32'h26f4743d;
    assign sda_line = host_sda & (sda_oe ? sda_out : 1'b1);
    vcc_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
    vcc_config_timing dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .hsync_in(hsync_in), .clamp_pin_in(clamp_pin_in),
        .line_divide_value(line_divide_value), .feedback_pulse(feedback_pulse), .vco_range(vco_range),
        .pump_current(pump_current), .sample_phase(sample_phase), .red_gain(red_gain),
        .green_gain(green_gain), .blue_gain(blue_gain), .red_offset(red_offset),
        .green_offset(green_offset), .sync_out(sync_out), .clamp_out(clamp_out));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // waits for the next line pulse and returns the cycles since the call
    task automatic wpulse(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (feedback_pulse !== 1'b1 && n < 5000);
        if (n >= 5000) chk(1'b0, 1'b1);
    endtask
    function automatic logic [7:0] exp_reset(input int a);
        case (a)
            0: exp_reset = vcc_pkg::VCC_SILICON_REV;
            1: exp_reset = 8'h69;
            2: exp_reset = 8'hD0;
            3: exp_reset = 8'h48;
            4: exp_reset = 8'h80;
            5: exp_reset = 8'h08;
            6: exp_reset = 8'h14;
            default: exp_reset = 8'h20;
        endcase
    endfunction
    function automatic logic [11:0] exp_line(input logic [7:0] h, input logic [3:0] l);
        exp_line = {h, l} + 12'h001;
    endfunction
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            results;
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chk(line_divide_value, 12'h69D);
        chk(vco_range, 2'b01);
        chk(pump_current, 3'b001);
        chk(sample_phase, 5'h10);
        chk(red_offset, 7'h3F);
        chk(green_offset, 7'h3F);
        for (int a = 0; a < 8; a++) begin
            host.rd(a[7:0], q);
            chk(q, exp_reset(a));
        end
        cur = 12'h69D;
        for (int i = 0; i < 2; i++) begin
            v = $random(seed);
            hi = i[7:0];
            lo = (i == 0) ? 4'h2 : v[3:0];
            host.wr(8'h01, hi);
            wpulse(k);
            wpulse(k);
            chk(line_divide_value, cur);
            chk(k, cur + 12'h001);
            host.wr(8'h02, {lo, 4'h0});
            wpulse(k);
            wpulse(k);
            cur = {hi, lo};
            chk(line_divide_value, cur);
            wpulse(k);
            chk(k, exp_line(hi, lo));
        end
        v = $random(seed);
        w = {5'h0, v[2:0]} + 8'h01;
        p = {5'h0, v[5:3]} + 8'h01;
        d = {5'h0, v[8:6]} + 8'h01;
        cg = v[23:16];
        ph = v[31:24];
        host.wr(8'h07, w);
        host.wr(8'h05, p);
        host.wr(8'h06, d);
        host.wr(8'h03, cg);
        host.wr(8'h04, ph);
        host.wr(8'h0B, 8'hFF);
        host.wr(8'h10, v[15:8]);
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            g[i] = v[7:0];
            host.wr(8'h08 + i[7:0], g[i]);
        end
        wpulse(k);
        wpulse(k);
        @(posedge sys_clk);
        #1;
        chk(sync_out, 1'b1);
        c = 1;
        repeat (12) begin
            @(posedge sys_clk);
            #1;
            if (sync_out === 1'b1) c++;
        end
        chk(c, w);
        chk(vco_range, cg[7:6]);
        chk(pump_current, cg[5:3]);
        chk(sample_phase, ph[7:3]);
        chk(red_gain, g[0]);
        chk(green_gain, g[1]);
        chk(blue_gain, g[2]);
        chk(red_offset, 7'h7F);
        host.rd(8'h0B, q);
        chk(q, 8'hFE);
        host.rd(8'h10, q);
        chk(q, 8'h00);
        hsync_in = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 hsync_in = 1'b0;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (clamp_out !== 1'b1 && k < 300);
        chk(k, p + 8'h02);
        c = 1;
        repeat (12) begin
            @(posedge sys_clk);
            #1;
            if (clamp_out === 1'b1) c++;
        end
        chk(c, d);
        host.wr(8'h0F, 8'h80);
        wpulse(k);
        wpulse(k);
        repeat (24) begin
            v = $random(seed);
            clamp_pin_in = v[0];
            hsync_in = v[1];
            @(posedge sys_clk);
            #1;
            chk(clamp_out, v[0]);
        end
        chk(host.nacks, 0);
        results;
    end
endmodule
